// *** hw/plut_defines.vh ***
/*
 * shared constants of the palette lookup block: host target codes,
 * colour sequence codes, reset values and the least low time of a host strobe.
 * assumes a 200 MHz system clock; included by bare name.
 */
`ifndef PLUT_DEFINES_VH
`define PLUT_DEFINES_VH

// host target select codes
`define PLUT_SEL_PTR_WR   2'h0
`define PLUT_SEL_PALETTE  2'h1
`define PLUT_SEL_MASK     2'h2
`define PLUT_SEL_PTR_RD   2'h3

// colour phase within a palette entry
`define PLUT_PH_RED       2'h0
`define PLUT_PH_GREEN     2'h1
`define PLUT_PH_BLUE      2'h2

// field layout of one 18-bit entry
`define PLUT_RED_LSB      12
`define PLUT_GRN_LSB      6
`define PLUT_BLU_LSB      0

// reset values
`define PLUT_MASK_RST     8'hFF
`define PLUT_PTR_RST      8'h00
`define PLUT_BLANK_CODE   6'h00

// least low time of a host strobe, and its cycle count at 5 ns
`define PLUT_STROBE_MIN_NS 50
`define PLUT_CLK_NS        5
`define PLUT_STROBE_CYC    ((`PLUT_STROBE_MIN_NS + `PLUT_CLK_NS - 1) / `PLUT_CLK_NS)

`endif

// *** hw/plut_palette_mem.v ***
/*
 * palette storage: 256 entries of 18 bits in flip-flops, one write
 * port from the host side and two combinational read ports.
 * assumes writes and reads share the system clock.
 */
`timescale 1ns/1ps

module plut_palette_mem #(
    parameter DEPTH_LOG2 = 8,
    parameter WIDTH      = 18
) (
    // clock
    input  wire                  clock_i,
    // write port
    input  wire                  wr_en_i,
    input  wire [DEPTH_LOG2-1:0] wr_addr_i,
    input  wire [WIDTH-1:0]      wr_data_i,
    // read ports
    input  wire [DEPTH_LOG2-1:0] rd_a_addr_i,
    output wire [WIDTH-1:0]      rd_a_data_o,
    input  wire [DEPTH_LOG2-1:0] rd_b_addr_i,
    output wire [WIDTH-1:0]      rd_b_data_o
);

    reg [WIDTH-1:0] mem_q [0:(1<<DEPTH_LOG2)-1];

    // no reset: palette content is undefined until software loads it
    always @(posedge clock_i)
    begin
        if (wr_en_i)
            mem_q[wr_addr_i] <= wr_data_i;
    end

    // index N reads entry N
    assign rd_a_data_o = mem_q[rd_a_addr_i];
    assign rd_b_data_o = mem_q[rd_b_addr_i];

endmodule // plut_palette_mem

// *** hw/plut_top.v ***
/*
 * palette lookup block: pixel path (index capture, mask, lookup,
 * blanking, colour codes) and asynchronous host port with pointer,
 * colour phase counter and pixel mask.
 * assumes the pixel clock is the system clock and the host strobes,
 * target select and host bus come from outside and are synchronised.
 */
`timescale 1ns/1ps
`include "plut_defines.vh"

module plut_top #(
    parameter IDX_W = 8,
    parameter CH_W  = 6
) (
    // clock and reset
    input  wire             clock_i,
    input  wire             rst_n_i,
    // pixel side
    input  wire [IDX_W-1:0] pixel_index_i,
    input  wire             video_suppress_n_i,
    // colour codes toward the converters
    output reg  [CH_W-1:0]  red_code_o,
    output reg  [CH_W-1:0]  green_code_o,
    output reg  [CH_W-1:0]  blue_code_o,
    // host port
    input  wire [1:0]       port_target_sel_i,
    input  wire             store_strobe_n_i,
    input  wire             fetch_strobe_n_i,
    input  wire [7:0]       host_bus_i,
    output reg  [7:0]       host_bus_o,
    output reg              host_bus_oe_n_o
);

    localparam ENT_W = 3 * CH_W;

    // pixel pipeline registers
    reg [IDX_W-1:0] pix_idx_q;
    reg             pix_vis_q;
    reg [IDX_W-1:0] look_idx_q;
    reg             look_vis_q;
    // host synchronisers, first stage read only by the second
    reg [1:0]       sel_s1_q;
    reg [1:0]       sel_s2_q;
    reg             st_s1_q;
    reg             st_s2_q;
    reg             st_s3_q;
    reg             fe_s1_q;
    reg             fe_s2_q;
    reg             fe_s3_q;
    reg [7:0]       bus_s1_q;
    reg [7:0]       bus_s2_q;
    reg [7:0]       bus_hold_q;
    reg [1:0]       sel_hold_q;
    // host state
    reg [IDX_W-1:0] ptr_q;
    reg [1:0]       phase_q;
    reg [IDX_W-1:0] mask_q;
    reg [CH_W-1:0]  red_lat_q;
    reg [CH_W-1:0]  grn_lat_q;
    reg [ENT_W-1:0] rd_ent_q;

    wire [ENT_W-1:0] pix_entry;
    wire [ENT_W-1:0] host_entry;
    wire             st_rise;
    wire             fe_fall;
    wire             fe_rise;
    wire             wr_blue;
    wire             mem_we;
    wire [ENT_W-1:0] mem_wdata;

    // capture index and suppress together so blanking stays aligned
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pix_idx_q  <= {IDX_W{1'b0}};
            pix_vis_q  <= 1'b0;
            look_idx_q <= {IDX_W{1'b0}};
            look_vis_q <= 1'b0;
        end
        else
        begin
            pix_idx_q  <= pixel_index_i;
            pix_vis_q  <= video_suppress_n_i;
            // masked index, forced to zero while suppressed
            look_idx_q <= pix_vis_q ? (pix_idx_q & mask_q) : {IDX_W{1'b0}};
            look_vis_q <= pix_vis_q;
        end
    end

    // split entry into channels; fixed two-edge latency from capture
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            red_code_o   <= `PLUT_BLANK_CODE;
            green_code_o <= `PLUT_BLANK_CODE;
            blue_code_o  <= `PLUT_BLANK_CODE;
        end
        else if (!look_vis_q)
        begin
            red_code_o   <= `PLUT_BLANK_CODE;
            green_code_o <= `PLUT_BLANK_CODE;
            blue_code_o  <= `PLUT_BLANK_CODE;
        end
        else
        begin
            red_code_o   <= pix_entry[`PLUT_RED_LSB +: CH_W];
            green_code_o <= pix_entry[`PLUT_GRN_LSB +: CH_W];
            blue_code_o  <= pix_entry[`PLUT_BLU_LSB +: CH_W];
        end
    end

    // strobes and bus come from another domain: two flops first
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sel_s1_q <= 2'h0;
            sel_s2_q <= 2'h0;
            st_s1_q  <= 1'b1;
            st_s2_q  <= 1'b1;
            st_s3_q  <= 1'b1;
            fe_s1_q  <= 1'b1;
            fe_s2_q  <= 1'b1;
            fe_s3_q  <= 1'b1;
            bus_s1_q <= 8'h00;
            bus_s2_q <= 8'h00;
        end
        else
        begin
            sel_s1_q <= port_target_sel_i;
            sel_s2_q <= sel_s1_q;
            st_s1_q  <= store_strobe_n_i;
            st_s2_q  <= st_s1_q;
            st_s3_q  <= st_s2_q;
            fe_s1_q  <= fetch_strobe_n_i;
            fe_s2_q  <= fe_s1_q;
            fe_s3_q  <= fe_s2_q;
            bus_s1_q <= host_bus_i;
            bus_s2_q <= bus_s1_q;
        end
    end

    // the synchroniser delays the strobe more than data settles, so
    // data sampled while the strobe is still low is the latched value
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus_hold_q <= 8'h00;
            sel_hold_q <= 2'h0;
        end
        else if (!st_s2_q || !fe_s2_q)
        begin
            bus_hold_q <= bus_s2_q;
            sel_hold_q <= sel_s2_q;
        end
    end

    assign st_rise   = st_s2_q & ~st_s3_q;
    assign fe_fall   = ~fe_s2_q & fe_s3_q;
    assign fe_rise   = fe_s2_q & ~fe_s3_q;
    assign wr_blue   = st_rise && (sel_hold_q == `PLUT_SEL_PALETTE) && (phase_q == `PLUT_PH_BLUE);
    assign mem_we    = wr_blue;
    assign mem_wdata = {red_lat_q, grn_lat_q, bus_hold_q[CH_W-1:0]};

    // pointer, phase counter, mask and colour latches
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ptr_q     <= `PLUT_PTR_RST;
            phase_q   <= `PLUT_PH_RED;
            mask_q    <= `PLUT_MASK_RST;
            red_lat_q <= {CH_W{1'b0}};
            grn_lat_q <= {CH_W{1'b0}};
        end
        else if (st_rise)
        begin
            case (sel_hold_q)
                `PLUT_SEL_PTR_WR:
                begin
                    ptr_q   <= bus_hold_q;
                    phase_q <= `PLUT_PH_RED;
                end
                `PLUT_SEL_PALETTE:
                begin
                    case (phase_q)
                        `PLUT_PH_RED:
                        begin
                            red_lat_q <= bus_hold_q[CH_W-1:0];
                            phase_q   <= `PLUT_PH_GREEN;
                        end
                        `PLUT_PH_GREEN:
                        begin
                            grn_lat_q <= bus_hold_q[CH_W-1:0];
                            phase_q   <= `PLUT_PH_BLUE;
                        end
                        default:
                        begin
                            ptr_q   <= ptr_q + 8'h01;
                            phase_q <= `PLUT_PH_RED;
                        end
                    endcase
                end
                `PLUT_SEL_MASK:
                    mask_q <= bus_hold_q;
                default:
                    phase_q <= phase_q; // pointer-read code writes nothing
            endcase
        end
        else if (fe_rise && (sel_hold_q == `PLUT_SEL_PALETTE))
        begin
            // reads step the phase; blue read advances and wraps
            case (phase_q)
                `PLUT_PH_RED:   phase_q <= `PLUT_PH_GREEN;
                `PLUT_PH_GREEN: phase_q <= `PLUT_PH_BLUE;
                default:
                begin
                    ptr_q   <= ptr_q + 8'h01;
                    phase_q <= `PLUT_PH_RED;
                end
            endcase
        end
    end

    // read data: snapshot entry at read start, drive bus while fetch low
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_ent_q        <= {ENT_W{1'b0}};
            host_bus_o      <= 8'h00;
            host_bus_oe_n_o <= 1'b1;
        end
        else
        begin
            if (fe_fall)
                rd_ent_q <= host_entry;
            // drive one edge after the snapshot so stale read data never shows
            host_bus_oe_n_o <= fe_s2_q | fe_s3_q;
            case (sel_s2_q)
                `PLUT_SEL_PTR_WR,
                `PLUT_SEL_PTR_RD: host_bus_o <= ptr_q;
                `PLUT_SEL_MASK:   host_bus_o <= mask_q;
                default:
                begin
                    case (phase_q)
                        `PLUT_PH_RED:   host_bus_o <= {2'b00, rd_ent_q[`PLUT_RED_LSB +: CH_W]};
                        `PLUT_PH_GREEN: host_bus_o <= {2'b00, rd_ent_q[`PLUT_GRN_LSB +: CH_W]};
                        default:        host_bus_o <= {2'b00, rd_ent_q[`PLUT_BLU_LSB +: CH_W]};
                    endcase
                end
            endcase
        end
    end

    plut_palette_mem #(
        .DEPTH_LOG2 (IDX_W),
        .WIDTH      (ENT_W)
    ) u_mem (
        .clock_i     (clock_i),
        .wr_en_i     (mem_we),
        .wr_addr_i   (ptr_q),
        .wr_data_i   (mem_wdata),
        .rd_a_addr_i (look_idx_q),
        .rd_a_data_o (pix_entry),
        .rd_b_addr_i (ptr_q),
        .rd_b_data_o (host_entry)
    );

endmodule // plut_top

// *** dv/plut_top_properties.sv ***
/* port checker for the palette lookup block.
   assumes one clock and the async active-low reset of plut_top. */
`timescale 1ns/1ps
module plut_checker #(
    parameter IDX_W = 8,
    parameter CH_W  = 6
) (
    // observed ports
    input logic             clock_i,
    input logic             rst_n_i,
    input logic [IDX_W-1:0] pixel_index_i,
    input logic             video_suppress_n_i,
    input logic [CH_W-1:0]  red_code_o,
    input logic [CH_W-1:0]  green_code_o,
    input logic [CH_W-1:0]  blue_code_o,
    input logic [1:0]       port_target_sel_i,
    input logic             store_strobe_n_i,
    input logic             fetch_strobe_n_i,
    input logic [7:0]       host_bus_o,
    input logic             host_bus_oe_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic [3:0] calm_q;
    // quiet pixel cycles; a store may rewrite the entry on show
    always_ff @(posedge clock_i or negedge rst_n_i)
        if (!rst_n_i)
            calm_q <= 4'h0;
        else if (!video_suppress_n_i || !store_strobe_n_i || pixel_index_i != $past(pixel_index_i))
            calm_q <= 4'h0;
        else if (calm_q != 4'hF)
            calm_q <= calm_q + 4'h1;
    a_blank_forces_zero: assert property (
        !video_suppress_n_i |-> ##3 {red_code_o, green_code_o, blue_code_o} == 18'h00000)
        else $error("codes not blanked");
    a_codes_hold_steady: assert property (
        calm_q >= 4'h8 |-> $stable({red_code_o, green_code_o, blue_code_o}))
        else $error("codes moved on a steady pixel");
    a_read_drives_soon: assert property (
        $fell(fetch_strobe_n_i) |-> ##[1:8] !host_bus_oe_n_o)
        else $error("read bus not driven in time");
    a_read_releases: assert property (
        $rose(fetch_strobe_n_i) |-> ##[1:6] host_bus_oe_n_o)
        else $error("read bus not released");
    a_idle_no_drive: assert property (
        fetch_strobe_n_i [*8] |-> host_bus_oe_n_o)
        else $error("bus driven without a read");
    a_drive_needs_fetch: assert property (
        $fell(host_bus_oe_n_o) |-> !$past(fetch_strobe_n_i, 2))
        else $error("drive began without fetch");
    a_colour_top_zero: assert property (
        !host_bus_oe_n_o && port_target_sel_i == 2'h1 |-> host_bus_o[7:6] == 2'h0)
        else $error("colour read top bits set");
    a_read_data_steady: assert property (
        !host_bus_oe_n_o && $past(!host_bus_oe_n_o) && !fetch_strobe_n_i |-> $stable(host_bus_o))
        else $error("read data moved");
    c_blank: cover property (!video_suppress_n_i ##3 1);
    c_read: cover property ($fell(host_bus_oe_n_o));
    c_calm: cover property (calm_q >= 4'h8 && red_code_o != 6'h00);
endmodule // plut_checker

bind plut_top plut_checker #(.IDX_W(IDX_W), .CH_W(CH_W)) u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .pixel_index_i(pixel_index_i),
    .video_suppress_n_i(video_suppress_n_i), .red_code_o(red_code_o),
    .green_code_o(green_code_o), .blue_code_o(blue_code_o),
    .port_target_sel_i(port_target_sel_i), .store_strobe_n_i(store_strobe_n_i),
    .fetch_strobe_n_i(fetch_strobe_n_i), .host_bus_o(host_bus_o),
    .host_bus_oe_n_o(host_bus_oe_n_o)
);

// *** dv/plut_host_model.sv ***
/* host processor model for the asynchronous host port.
   assumes the bench clock; signals move just after a rising edge. */
`timescale 1ns/1ps
module plut_host_model (
    // clock
    input  logic       clock_i,
    // design side of the bus
    input  logic [7:0] dut_bus_i,
    input  logic       dut_oe_n_i,
    // host controls and resolved bus
    output logic [1:0] sel_o,
    output logic       store_strobe_n_o,
    output logic       fetch_strobe_n_o,
    output logic [7:0] bus_o
);
    logic       drv_q = 1'b0;
    logic [7:0] wdat_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    initial sel_o = 2'h0;
    initial store_strobe_n_o = 1'b1;
    initial fetch_strobe_n_o = 1'b1;
    // released bus toggles each cycle so stale data never matches
    assign bus_o = !dut_oe_n_i ? dut_bus_i : (drv_q ? wdat_q : ~last_q);
    always @(posedge clock_i) last_q <= bus_o;
    // select set three cycles ahead to cover its synchroniser
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge clock_i);
        sel_o <= sel;
        wdat_q <= d;
        drv_q <= 1'b1;
        repeat (3) @(posedge clock_i);
        store_strobe_n_o <= 1'b0;
        repeat (10) @(posedge clock_i);
        store_strobe_n_o <= 1'b1;
        repeat (4) @(posedge clock_i);
        drv_q <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask
    // fetch held low through the sample edge
    task automatic rd(input logic [1:0] sel, output logic [7:0] d);
        @(posedge clock_i);
        sel_o <= sel;
        repeat (3) @(posedge clock_i);
        fetch_strobe_n_o <= 1'b0;
        repeat (10) @(posedge clock_i);
        d = bus_o;
        fetch_strobe_n_o <= 1'b1;
        repeat (6) @(posedge clock_i);
    endtask
endmodule // plut_host_model

// *** dv/plut_top_test.sv ***
/* self-checking bench of plut_top with the host model.
   assumes a 200 MHz clock and that the bench drives the pixel side. */
`timescale 1ns/1ps
module plut_top_test;
    localparam logic [17:0] ENT_HI = {6'h2B, 6'h15, 6'h3C};
    localparam logic [17:0] ENT_LO = {6'h01, 6'h3E, 6'h20};
    logic       clock_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic [7:0] pixel_index_i = 8'h00;
    // blank until a pixel test: palette storage is unknown before loading
    logic       video_suppress_n_i = 1'b0;
    logic [5:0] red_code_o, green_code_o, blue_code_o;
    logic [1:0] sel;
    logic       store_n, fetch_n, oe_n;
    logic [7:0] bus_in, bus_out, rd_d;
    int         error_cnt = 0;
    int         checks = 0;
    int         cyc = 0;
    plut_top #(.IDX_W(8), .CH_W(6)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .pixel_index_i(pixel_index_i),
        .video_suppress_n_i(video_suppress_n_i), .red_code_o(red_code_o),
        .green_code_o(green_code_o), .blue_code_o(blue_code_o),
        .port_target_sel_i(sel), .store_strobe_n_i(store_n), .fetch_strobe_n_i(fetch_n),
        .host_bus_i(bus_in), .host_bus_o(bus_out), .host_bus_oe_n_o(oe_n)
    );
    plut_host_model u_host (
        .clock_i(clock_i), .dut_bus_i(bus_out), .dut_oe_n_i(oe_n), .sel_o(sel),
        .store_strobe_n_o(store_n), .fetch_strobe_n_o(fetch_n), .bus_o(bus_in)
    );
    initial forever #2.5 clock_i = ~clock_i;
    // hang guard: the whole run needs well under 3000 cycles
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // pointer load then three colour writes; top bits set to be ignored
    task automatic put_entry(input logic [7:0] idx, input logic [17:0] e);
        u_host.wr(2'h0, idx);
        u_host.wr(2'h1, {2'h3, e[17:12]});
        u_host.wr(2'h1, {2'h3, e[11:6]});
        u_host.wr(2'h1, {2'h3, e[5:0]});
    endtask
    // hold one pixel long enough for the three-edge pipeline
    task automatic pix(input logic [7:0] i, input logic v, input logic [17:0] exp);
        @(posedge clock_i);
        pixel_index_i <= i;
        video_suppress_n_i <= v;
        repeat (5) @(posedge clock_i);
        #1 check({red_code_o, green_code_o, blue_code_o}, exp);
    endtask
    task automatic t_reset();
        #1 check({11'h000, oe_n, red_code_o}, 18'h00040);
        u_host.rd(2'h2, rd_d);
        check({10'h000, rd_d}, 18'h000FF);
        u_host.rd(2'h3, rd_d);
        check({10'h000, rd_d}, 18'h00000);
        $display("t_reset done");
    endtask
    task automatic t_palette();
        put_entry(8'hFF, ENT_HI);
        u_host.rd(2'h3, rd_d);
        check({10'h000, rd_d}, 18'h00000);
        put_entry(8'h00, ENT_LO);
        u_host.rd(2'h3, rd_d);
        check({10'h000, rd_d}, 18'h00001);
        u_host.wr(2'h0, 8'hFF);
        for (int k = 2; k >= 0; k--)
        begin
            u_host.rd(2'h1, rd_d);
            check({10'h000, rd_d}, {12'h000, ENT_HI[k*6 +: 6]});
        end
        u_host.rd(2'h3, rd_d);
        check({10'h000, rd_d}, 18'h00000);
        // a write with the pointer-read code must leave the pointer alone
        u_host.wr(2'h3, 8'h55);
        u_host.rd(2'h0, rd_d);
        check({10'h000, rd_d}, 18'h00000);
        $display("t_palette done");
    endtask
    task automatic t_pixels();
        pix(8'hFF, 1'b1, ENT_HI);
        pix(8'hFF, 1'b0, 18'h00000);
        pix(8'h00, 1'b1, ENT_LO);
        u_host.wr(2'h2, 8'h00);
        pix(8'hFF, 1'b1, ENT_LO);
        u_host.wr(2'h2, 8'hFF);
        pix(8'hFF, 1'b1, ENT_HI);
        $display("t_pixels done");
    endtask
    initial
    begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        t_reset();
        t_palette();
        t_pixels();
        print_verdict();
    end
endmodule // plut_top_test
